/* File: include/ibsp_pkg.sv */
package ibsp_pkg;

   // ==========================================
   // command letters
   localparam logic [7:0] PARITY_LETTER = 8'h4b;
   localparam logic [7:0] DELIM_LETTER = 8'h55;
   localparam logic [7:0] DSRQ_LETTER = 8'h51;
   localparam logic [7:0] POLL_LETTER = 8'h4a;
   localparam logic [7:0] FORMAT_LETTER = 8'h42;

   // ==========================================
   // argument limits
   localparam logic [3:0] PARITY_MAX = 4'h3;
   localparam logic [3:0] DELIM_MAX = 4'h7;
   localparam logic [3:0] DSRQ_MAX = 4'h1;
   localparam logic [3:0] POLL_MAX = 4'h8;
   localparam logic [3:0] FORMAT_MAX_DEF = 4'h3;

   // ==========================================
   // values after reset
   localparam logic [1:0] PARITY_RST = 2'h0;
   localparam logic [2:0] DELIM_RST = 3'h0;
   localparam logic DSRQ_RST = 1'b0;
   localparam logic [3:0] POLL_RST = 4'h0;
   localparam logic [3:0] FORMAT_RST = 4'h0;

   // ==========================================
   // parity settings
   localparam logic [1:0] PAR_OFF = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ON = 2'h3;

   // ==========================================
   // status byte fields
   localparam int STAT_RQS = 6;
   localparam int STAT_AVAIL = 4;
   localparam int STAT_REMOTE = 3;
   localparam logic [2:0] ERR_NONE = 3'h0;
   localparam logic [2:0] ERR_RANGE = 3'h4;
   localparam logic [2:0] ERR_UNREC = 3'h5;

   // ==========================================
   // delimiter characters
   localparam logic [7:0] CHAR_CR = 8'h0d;
   localparam logic [7:0] CHAR_LF = 8'h0a;
   localparam logic [7:0] CHAR_SEMI = 8'h3b;
   localparam logic [7:0] CHAR_ETX = 8'h03;

   localparam int BUF_DEPTH = 2;

   typedef enum logic [2:0] {PH_DATA, PH_CR, PH_LF, PH_SEMI, PH_ETX} ibsp_phase_e;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } ibsp_char_s;

   typedef struct packed {
      logic [7:0] letter;
      logic [3:0] value;
   } ibsp_cmd_s;

endpackage

/* File: core/ibsp_buf.sv */
`timescale 1ns/10ps
module ibsp_buf #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= bump(wr_q);
         end
         if (pop) begin
            rd_q <= bump(rd_q);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

/* File: core/ibsp_top.sv */
`timescale 1ns/10ps
module ibsp_top #(
   parameter logic [3:0] FORMAT_MAX = ibsp_pkg::FORMAT_MAX_DEF
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic cmd_valid,
   input wire ibsp_pkg::ibsp_cmd_s cmd,
   input wire logic cmd_foreign_ok,
   output logic cmd_ready_q,
   input wire logic in_valid,
   input wire ibsp_pkg::ibsp_char_s in_char,
   output logic in_ready,
   input wire logic remote_state,
   input wire logic talk_addr,
   input wire logic spoll_en,
   input wire logic ppoll_req,
   input wire logic bus_take,
   output logic [7:0] dio_q,
   output logic [7:0] dio_oe_q,
   output logic eoi_q,
   output logic eoi_oe_q,
   output logic srq_oe_q,
   output logic [7:0] pp_dio_q,
   output logic [7:0] pp_oe_q,
   output logic [7:0] iface_status_q,
   output logic [3:0] format_sel_q
);

   // ==========================================
   // settings and state
   logic [1:0] parity_q;
   logic [2:0] delim_q;
   logic dsrq_en_q;
   logic [3:0] poll_line_q;
   logic [2:0] err_q;
   logic [2:0] err_d;
   logic rqs_q;
   logic rqs_d;
   logic avail_q;
   logic avail_now;
   logic tx_valid_q;
   logic tx_stat_q;
   logic stat_sent_q;
   ibsp_pkg::ibsp_phase_e ph_q;
   ibsp_pkg::ibsp_phase_e ph_d;

   logic cmd_take;
   logic cmd_err;
   logic [2:0] cmd_code;
   logic buf_valid;
   ibsp_pkg::ibsp_char_s buf_char;
   logic buf_pop;
   logic can_load;
   logic load_stat;
   logic load_data;
   logic stat_done;
   logic emit_ok;
   logic [7:0] emit_char;
   logic emit_eoi;
   logic [7:0] status_now;

   // ==========================================
   // helpers
   function automatic logic [7:0] add_parity(input logic [7:0] c, input logic [1:0] mode);
      logic [7:0] r;
      r = {1'b0, c[6:0]};
      case (mode)
         ibsp_pkg::PAR_ODD: r[7] = ~^c[6:0];
         ibsp_pkg::PAR_EVEN: r[7] = ^c[6:0];
         ibsp_pkg::PAR_ON: r[7] = 1'b1;
         default: r[7] = 1'b0;
      endcase
      return r;
   endfunction

   function automatic ibsp_pkg::ibsp_phase_e first_delim(input logic [2:0] d);
      case (d)
         3'h1: first_delim = ibsp_pkg::PH_SEMI;
         3'h2, 3'h6: first_delim = ibsp_pkg::PH_ETX;
         3'h4: first_delim = ibsp_pkg::PH_DATA;
         default: first_delim = ibsp_pkg::PH_CR;
      endcase
   endfunction

   // ==========================================
   // output stream buffer
   ibsp_buf #(
      .WIDTH($bits(ibsp_pkg::ibsp_char_s)),
      .DEPTH(ibsp_pkg::BUF_DEPTH)
   ) u_buf (
      .clock(clock),
      .nrst(nrst),
      .in_valid(in_valid),
      .in_data(in_char),
      .in_ready(in_ready),
      .out_valid(buf_valid),
      .out_data(buf_char),
      .out_ready(buf_pop)
   );

   // ==========================================
   // command checking
   assign cmd_take = cmd_valid & cmd_ready_q;

   always_comb begin
      cmd_code = ibsp_pkg::ERR_NONE;
      case (cmd.letter)
         ibsp_pkg::PARITY_LETTER: if (cmd.value > ibsp_pkg::PARITY_MAX) cmd_code = ibsp_pkg::ERR_RANGE;
         ibsp_pkg::DELIM_LETTER: if (cmd.value > ibsp_pkg::DELIM_MAX) cmd_code = ibsp_pkg::ERR_RANGE;
         ibsp_pkg::DSRQ_LETTER: if (cmd.value > ibsp_pkg::DSRQ_MAX) cmd_code = ibsp_pkg::ERR_RANGE;
         ibsp_pkg::POLL_LETTER: if (cmd.value > ibsp_pkg::POLL_MAX) cmd_code = ibsp_pkg::ERR_RANGE;
         ibsp_pkg::FORMAT_LETTER: if (cmd.value > FORMAT_MAX) cmd_code = ibsp_pkg::ERR_RANGE;
         default: if (!cmd_foreign_ok) cmd_code = ibsp_pkg::ERR_UNREC;
      endcase
   end

   assign cmd_err = cmd_take & (cmd_code != ibsp_pkg::ERR_NONE);

   // settings change only on a clean command
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         parity_q <= ibsp_pkg::PARITY_RST;
         delim_q <= ibsp_pkg::DELIM_RST;
         dsrq_en_q <= ibsp_pkg::DSRQ_RST;
         poll_line_q <= ibsp_pkg::POLL_RST;
         format_sel_q <= ibsp_pkg::FORMAT_RST;
      end else if (cmd_take && !cmd_err) begin
         case (cmd.letter)
            ibsp_pkg::PARITY_LETTER: parity_q <= cmd.value[1:0];
            ibsp_pkg::DELIM_LETTER: delim_q <= cmd.value[2:0];
            ibsp_pkg::DSRQ_LETTER: dsrq_en_q <= cmd.value[0];
            ibsp_pkg::POLL_LETTER: poll_line_q <= cmd.value;
            ibsp_pkg::FORMAT_LETTER: format_sel_q <= cmd.value;
            default: ;
         endcase
      end
   end

   // ==========================================
   // talker: data, delimiters, status byte
   assign can_load = !tx_valid_q | (bus_take & dio_oe_q[0]);

   always_comb begin
      emit_ok = 1'b0;
      emit_char = 8'h00;
      emit_eoi = 1'b0;
      ph_d = ph_q;
      buf_pop = 1'b0;
      case (ph_q)
         ibsp_pkg::PH_DATA: begin
            if (buf_valid) begin
               emit_ok = 1'b1;
               emit_char = buf_char.data;
               if (buf_char.last) begin
                  ph_d = first_delim(delim_q);
                  emit_eoi = (delim_q == 3'h4);
               end
            end
         end
         ibsp_pkg::PH_CR: begin
            emit_ok = 1'b1;
            emit_char = ibsp_pkg::CHAR_CR;
            ph_d = ibsp_pkg::PH_LF;
         end
         ibsp_pkg::PH_LF: begin
            emit_ok = 1'b1;
            emit_char = ibsp_pkg::CHAR_LF;
            ph_d = delim_q[1] ? ibsp_pkg::PH_ETX : ibsp_pkg::PH_DATA;
            emit_eoi = delim_q[2] & !delim_q[1];
         end
         ibsp_pkg::PH_SEMI: begin
            emit_ok = 1'b1;
            emit_char = ibsp_pkg::CHAR_SEMI;
            ph_d = ibsp_pkg::PH_DATA;
         end
         ibsp_pkg::PH_ETX: begin
            emit_ok = 1'b1;
            emit_char = ibsp_pkg::CHAR_ETX;
            ph_d = ibsp_pkg::PH_DATA;
            emit_eoi = delim_q[2];
         end
         default: ph_d = ibsp_pkg::PH_DATA;
      endcase
      load_stat = can_load & spoll_en & talk_addr & !stat_sent_q & !stat_done & !ppoll_req;
      load_data = can_load & !spoll_en & talk_addr & !ppoll_req & emit_ok;
      if (!load_data) begin
         ph_d = ph_q;
      end else if (ph_q == ibsp_pkg::PH_DATA) begin
         buf_pop = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ph_q <= ibsp_pkg::PH_DATA;
      end else begin
         ph_q <= ph_d;
      end
   end

   // the byte register is the dio driver itself
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tx_valid_q <= 1'b0;
         tx_stat_q <= 1'b0;
         dio_q <= 8'h00;
         dio_oe_q <= 8'h00;
         eoi_q <= 1'b0;
         eoi_oe_q <= 1'b0;
      end else if (can_load) begin
         tx_valid_q <= load_stat | load_data;
         tx_stat_q <= load_stat;
         dio_oe_q <= (load_stat | load_data) ? 8'hff : 8'h00;
         eoi_oe_q <= load_stat | load_data;
         if (load_stat) begin
            dio_q <= status_now;
            eoi_q <= 1'b0;
         end else if (load_data) begin
            dio_q <= add_parity(emit_char, parity_q);
            eoi_q <= emit_eoi;
         end
      end else if (ppoll_req) begin
         // byte held for later, bus released for the poll
         dio_oe_q <= 8'h00;
         eoi_oe_q <= 1'b0;
      end else begin
         dio_oe_q <= tx_valid_q ? 8'hff : 8'h00;
         eoi_oe_q <= tx_valid_q;
      end
   end

   assign stat_done = tx_valid_q & tx_stat_q & bus_take & dio_oe_q[0];

   // one status byte per poll; re-armed when the poll ends
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stat_sent_q <= 1'b0;
      end else if (!spoll_en) begin
         stat_sent_q <= 1'b0;
      end else if (stat_done) begin
         stat_sent_q <= 1'b1;
      end
   end

   // ==========================================
   // service request and status byte
   assign avail_now = buf_valid | (ph_q != ibsp_pkg::PH_DATA) | (tx_valid_q & !tx_stat_q);

   always_comb begin
      rqs_d = rqs_q;
      err_d = err_q;
      if (stat_done) begin
         rqs_d = 1'b0;
         err_d = ibsp_pkg::ERR_NONE;
      end
      // a new cause in the delivery cycle wins
      if (dsrq_en_q && avail_now && !avail_q) begin
         rqs_d = 1'b1;
      end
      if (cmd_err) begin
         rqs_d = 1'b1;
         err_d = cmd_code;
      end
   end

   always_comb begin
      status_now = 8'h00;
      status_now[2:0] = err_q;
      status_now[ibsp_pkg::STAT_REMOTE] = remote_state;
      status_now[ibsp_pkg::STAT_AVAIL] = avail_q;
      status_now[ibsp_pkg::STAT_RQS] = rqs_q;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rqs_q <= 1'b0;
         err_q <= ibsp_pkg::ERR_NONE;
         avail_q <= 1'b0;
         srq_oe_q <= 1'b0;
         iface_status_q <= 8'h00;
      end else begin
         rqs_q <= rqs_d;
         err_q <= err_d;
         avail_q <= avail_now;
         srq_oe_q <= rqs_d;
         iface_status_q <= status_now;
      end
   end

   // new commands wait while an error request is unanswered
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cmd_ready_q <= 1'b0;
      end else begin
         cmd_ready_q <= (err_d == ibsp_pkg::ERR_NONE);
      end
   end

   // ==========================================
   // parallel poll response
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pp_dio_q <= 8'h00;
         pp_oe_q <= 8'h00;
      end else if (ppoll_req && rqs_q && poll_line_q != 4'h0) begin
         pp_dio_q <= 8'h01 << (poll_line_q - 4'h1);
         pp_oe_q <= 8'h01 << (poll_line_q - 4'h1);
      end else begin
         pp_dio_q <= 8'h00;
         pp_oe_q <= 8'h00;
      end
   end

endmodule

/* File: tb/ibsp_acceptor.sv */
`timescale 1ns/10ps
// ==========================================
// bus acceptor: takes each presented byte after a stall set by the bench
module ibsp_acceptor (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] dio_q,
   input wire logic [7:0] dio_oe_q,
   input wire logic eoi_q,
   input wire logic eoi_oe_q,
   input wire logic [1:0] stall,
   output logic bus_take,
   output logic rx_stb,
   output logic [7:0] rx_byte,
   output logic rx_eoi
);
   logic [1:0] wait_q;
   // one-cycle take pulse, never two on the same byte
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bus_take <= 1'b0;
         wait_q <= 2'h0;
      end else if (dio_oe_q == 8'hff && !bus_take && wait_q >= stall) begin
         bus_take <= 1'b1;
         wait_q <= 2'h0;
      end else begin
         bus_take <= 1'b0;
         if (dio_oe_q == 8'hff) begin
            wait_q <= wait_q + 2'h1;
         end
      end
   end
   // byte and end flag captured at the taking edge
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rx_stb <= 1'b0;
         rx_byte <= 8'h00;
         rx_eoi <= 1'b0;
      end else begin
         rx_stb <= bus_take && dio_oe_q == 8'hff;
         rx_byte <= dio_q;
         rx_eoi <= eoi_oe_q && eoi_q;
      end
   end
endmodule

/* File: tb/ibsp_checker_properties.sv */
`timescale 1ns/10ps
module ibsp_checker #(
   parameter logic [3:0] FORMAT_MAX = 4'h3
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic cmd_valid,
   input wire ibsp_pkg::ibsp_cmd_s cmd,
   input wire logic cmd_foreign_ok,
   input wire logic cmd_ready_q,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic remote_state,
   input wire logic spoll_en,
   input wire logic ppoll_req,
   input wire logic bus_take,
   input wire logic [7:0] dio_q,
   input wire logic [7:0] dio_oe_q,
   input wire logic srq_oe_q,
   input wire logic [7:0] pp_dio_q,
   input wire logic [7:0] pp_oe_q,
   input wire logic [7:0] iface_status_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   logic take, known, over;
   assign take = cmd_valid && cmd_ready_q;
   assign known = cmd.letter inside {ibsp_pkg::PARITY_LETTER, ibsp_pkg::DELIM_LETTER, ibsp_pkg::DSRQ_LETTER,
      ibsp_pkg::POLL_LETTER, ibsp_pkg::FORMAT_LETTER};
   always_comb begin
      case (cmd.letter)
         ibsp_pkg::PARITY_LETTER: over = cmd.value > ibsp_pkg::PARITY_MAX;
         ibsp_pkg::DELIM_LETTER: over = cmd.value > ibsp_pkg::DELIM_MAX;
         ibsp_pkg::DSRQ_LETTER: over = cmd.value > ibsp_pkg::DSRQ_MAX;
         ibsp_pkg::POLL_LETTER: over = cmd.value > ibsp_pkg::POLL_MAX;
         default: over = cmd.value > FORMAT_MAX;
      endcase
   end
   // ==========================================
   // command checking
   a_bad_letter: assert property (take && !known && !cmd_foreign_ok && !spoll_en
      |=> srq_oe_q && !cmd_ready_q ##1 iface_status_q[2:0] == 3'h5) else $error("unknown letter not flagged");
   a_range_err: assert property (take && known && over && !spoll_en
      |=> srq_oe_q && !cmd_ready_q ##1 iface_status_q[2:0] == 3'h4) else $error("range error not flagged");
   a_good_cmd: assert property (take && known && !over |=> cmd_ready_q) else $error("valid command refused");
   a_err_stall: assert property (srq_oe_q && iface_status_q[2:0] != 3'h0 && !bus_take && !$past(bus_take)
      |=> !cmd_ready_q) else $error("command taken while error pending");
   // ==========================================
   // polls and status
   a_pp_idle: assert property (!ppoll_req |=> pp_oe_q == 8'h00) else $error("poll line driven outside poll");
   a_pp_shape: assert property (ppoll_req |=> $onehot0(pp_oe_q) && pp_dio_q == pp_oe_q)
      else $error("poll response not one line");
   a_pp_quiet: assert property (ppoll_req && !srq_oe_q |=> pp_oe_q == 8'h00) else $error("poll answered without srq");
   a_remote_bit: assert property ($past(nrst, 2) && remote_state == $past(remote_state) &&
      remote_state == $past(remote_state, 2) |-> iface_status_q[3] == remote_state) else $error("remote bit wrong");
   a_avail_bit: assert property (in_valid && in_ready |-> ##3 iface_status_q[4]) else $error("avail bit missing");
   a_rqs_bit: assert property ($rose(srq_oe_q) |=> iface_status_q[6]) else $error("rqs bit missing");
   a_poll_release: assert property (spoll_en && bus_take && dio_oe_q == 8'hff && dio_q == iface_status_q &&
      !cmd_valid && !in_valid |=> !srq_oe_q) else $error("srq kept after poll");
   cover property (take && !known && !cmd_foreign_ok);
   cover property (ppoll_req && srq_oe_q);
   cover property (spoll_en && bus_take);
endmodule
bind ibsp_top ibsp_checker #(.FORMAT_MAX(FORMAT_MAX)) chk (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
   .cmd_foreign_ok(cmd_foreign_ok), .cmd_ready_q(cmd_ready_q), .in_valid(in_valid), .in_ready(in_ready),
   .remote_state(remote_state), .spoll_en(spoll_en), .ppoll_req(ppoll_req), .bus_take(bus_take), .dio_q(dio_q),
   .dio_oe_q(dio_oe_q), .srq_oe_q(srq_oe_q), .pp_dio_q(pp_dio_q), .pp_oe_q(pp_oe_q), .iface_status_q(iface_status_q));

/* File: tb/ibsp_bench.sv */
`timescale 1ns/10ps
module ibsp_bench;
   logic clock = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_foreign_ok = 1'b0, in_valid = 1'b0;
   logic remote_state = 1'b0, talk_addr = 1'b0, spoll_en = 1'b0, ppoll_req = 1'b0;
   ibsp_pkg::ibsp_cmd_s cmd = '0;
   ibsp_pkg::ibsp_char_s in_char = '0;
   logic [1:0] stall = 2'h0;
   logic cmd_ready_q, in_ready, bus_take, eoi_q, eoi_oe_q, srq_oe_q, rx_stb, rx_eoi;
   logic [7:0] dio_q, dio_oe_q, pp_dio_q, pp_oe_q, iface_status_q, rx_byte;
   logic [3:0] format_sel_q;
   logic [15:0] lf = 16'h37ce;
   logic [8:0] rxq[$], expq[$];
   // letter, value, expected error code
   logic [14:0] bad [6] = '{{8'h53, 4'h0, 3'h5}, {ibsp_pkg::PARITY_LETTER, 4'h4, 3'h4},
      {ibsp_pkg::DELIM_LETTER, 4'h8, 3'h4}, {ibsp_pkg::DSRQ_LETTER, 4'h2, 3'h4},
      {ibsp_pkg::POLL_LETTER, 4'h9, 3'h4}, {ibsp_pkg::FORMAT_LETTER, 4'h4, 3'h4}};
   int n_fail = 0, checks = 0;
   always #25 clock = ~clock;
   ibsp_top #(.FORMAT_MAX(4'h3)) uut (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_foreign_ok(cmd_foreign_ok), .cmd_ready_q(cmd_ready_q), .in_valid(in_valid), .in_char(in_char),
      .in_ready(in_ready), .remote_state(remote_state), .talk_addr(talk_addr), .spoll_en(spoll_en),
      .ppoll_req(ppoll_req), .bus_take(bus_take), .dio_q(dio_q), .dio_oe_q(dio_oe_q), .eoi_q(eoi_q),
      .eoi_oe_q(eoi_oe_q), .srq_oe_q(srq_oe_q), .pp_dio_q(pp_dio_q), .pp_oe_q(pp_oe_q),
      .iface_status_q(iface_status_q), .format_sel_q(format_sel_q));
   ibsp_acceptor partner (.clock(clock), .nrst(nrst), .dio_q(dio_q), .dio_oe_q(dio_oe_q), .eoi_q(eoi_q),
      .eoi_oe_q(eoi_oe_q), .stall(stall), .bus_take(bus_take), .rx_stb(rx_stb), .rx_byte(rx_byte), .rx_eoi(rx_eoi));
   always @(posedge clock) if (rx_stb) rxq.push_back({rx_eoi, rx_byte});
   // ==========================================
   // helpers
   function automatic logic [15:0] nxt(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] wp(logic [6:0] d, logic [1:0] p);
      case (p)
         ibsp_pkg::PAR_OFF: return {1'b0, d};
         ibsp_pkg::PAR_ODD: return {~^d, d};
         ibsp_pkg::PAR_EVEN: return {^d, d};
         default: return {1'b1, d};
      endcase
   endfunction
   task step(int n = 1);
      repeat (n) @(posedge clock);
      #5;
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(string nm, logic [8:0] seen, logic [8:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
         n_fail++;
      end
   endtask
   task timeout(string nm);
      $display("[ERR] %s exp done seen timeout", nm);
      n_fail++;
      results();
   endtask
   task send(logic [7:0] l, logic [3:0] v, logic f = 1'b0);
      int i;
      for (i = 0; i < 50 && !cmd_ready_q; i++) step();
      if (!cmd_ready_q) timeout("cmd_ready_q");
      cmd_valid = 1'b1;
      cmd = {l, v};
      cmd_foreign_ok = f;
      step();
      cmd_valid = 1'b0;
      step(3);
   endtask
   task push(logic [8:0] c);
      int i;
      in_valid = 1'b1;
      in_char = c;
      for (i = 0; i < 200 && !in_ready; i++) step();
      if (!in_ready) timeout("in_ready");
      step();
   endtask
   task drain;
      int i;
      for (i = 0; i < 400 && rxq.size() < expq.size(); i++) step();
      if (rxq.size() < expq.size()) timeout("rx");
      foreach (expq[k]) chk("rx", rxq[k], expq[k]);
   endtask
   // expected stream: data with parity, then the selected delimiter
   task msg(int n, logic [1:0] p, logic [2:0] d);
      logic [6:0] c;
      int i;
      rxq.delete();
      expq.delete();
      lf = nxt(lf);
      stall = lf[1:0];
      for (i = 0; i < n; i++) begin
         lf = nxt(lf);
         c = lf[6:0];
         expq.push_back({d == 3'h4 && i == n - 1, wp(c, p)});
         push({1'b0, c, i == n - 1});
      end
      in_valid = 1'b0;
      if (d == 3'h1) expq.push_back({1'b0, wp(7'h3b, p)});
      if (d inside {0, 3, 5, 7}) begin
         expq.push_back({1'b0, wp(7'h0d, p)});
         expq.push_back({d == 3'h5, wp(7'h0a, p)});
      end
      if (d inside {2, 3, 6, 7}) expq.push_back({d > 3'h5, wp(7'h03, p)});
      drain();
   endtask
   task poll(logic [7:0] exp);
      int i;
      rxq.delete();
      spoll_en = 1'b1;
      talk_addr = 1'b1;
      for (i = 0; i < 50 && rxq.size() == 0; i++) step();
      if (rxq.size() == 0) timeout("poll");
      spoll_en = 1'b0;
      step(2);
      chk("status_byte", rxq[0], {1'b0, exp});
      chk("poll_once", 9'(rxq.size()), 9'h001);
      chk("srq_release", srq_oe_q, 1'b0);
      chk("ready_back", cmd_ready_q, 1'b1);
   endtask
   // ==========================================
   // main sequence
   initial begin
      int i;
      step(10);
      nrst = 1'b1;
      step(2);
      chk("status_rst", iface_status_q, 8'h00);
      chk("ready_rst", cmd_ready_q, 1'b1);
      talk_addr = 1'b1;
      msg(3, 2'h0, 3'h0);
      chk("srq_q0", srq_oe_q, 1'b0);
      for (i = 0; i < 8; i++) begin
         lf = nxt(lf);
         send(ibsp_pkg::PARITY_LETTER, 4'(i % 4));
         send(ibsp_pkg::DELIM_LETTER, 4'(i));
         msg(int'(lf[1:0]) + 1, 2'(i % 4), 3'(i));
      end
      // fill the buffer while not talking, then drain
      send(ibsp_pkg::PARITY_LETTER, 4'h0);
      send(ibsp_pkg::DELIM_LETTER, 4'h4);
      send(ibsp_pkg::FORMAT_LETTER, 4'h2);
      remote_state = 1'b1;
      talk_addr = 1'b0;
      rxq.delete();
      in_valid = 1'b1;
      for (i = 0; i < 5 && in_ready; i++) begin
         in_char = {8'h41 + 8'(i), i == 1};
         step();
      end
      in_valid = 1'b0;
      chk("fill", 9'(i), 9'(ibsp_pkg::BUF_DEPTH));
      step(2);
      chk("status_q0", iface_status_q, 8'h18);
      talk_addr = 1'b1;
      expq = '{9'h041, 9'h142};
      drain();
      // data request, parallel then serial poll
      send(ibsp_pkg::DSRQ_LETTER, 4'h1);
      talk_addr = 1'b0;
      push(9'h0ab);
      in_valid = 1'b0;
      for (i = 0; i < 20 && !srq_oe_q; i++) step();
      chk("srq_q1", srq_oe_q, 1'b1);
      for (i = 0; i < 9; i++) begin
         send(ibsp_pkg::POLL_LETTER, 4'(i));
         ppoll_req = 1'b1;
         step(2);
         chk("pp_oe", pp_oe_q, i ? 9'h001 << (i - 1) : 9'h000);
         chk("pp_dio", pp_dio_q, i ? 9'h001 << (i - 1) : 9'h000);
         ppoll_req = 1'b0;
         step(2);
         chk("pp_idle", pp_oe_q, 8'h00);
      end
      poll(8'h58);
      ppoll_req = 1'b1;
      step(2);
      chk("pp_quiet", pp_oe_q, 8'h00);
      ppoll_req = 1'b0;
      expq = '{9'h058, 9'h155};
      drain();
      // invalid commands: flagged, refused, then cleared by the poll
      for (i = 0; i < 6; i++) begin
         send(bad[i][14:7], bad[i][6:3]);
         chk("error", iface_status_q, {5'h09, bad[i][2:0]});
         chk("refused", cmd_ready_q, 1'b0);
         poll({5'h09, bad[i][2:0]});
      end
      send(8'h53, 4'h0, 1'b1);
      chk("foreign", iface_status_q, 8'h08);
      chk("format", format_sel_q, 4'h2);
      msg(2, 2'h0, 3'h4);
      results();
   end
endmodule
